//--- ecb_enc_model.sv
// Purpose: Encoder stand-in answering each frame with decoded fields
// Assumes: Reply is offered a few cycles after the frame ends
// Notes:   Fields show inverted values outside the reply pulse
`timescale 1ns/10ps
module ecb_enc_model #(
    parameter logic [12:0] POS   = 13'h1d3e,
    parameter logic [11:0] TURNS = 12'h744,
    parameter logic        ALARM = 1'b1,
    parameter logic [15:0] PARAM = 16'h1234
) (
    input  wire logic        aclk,
    input  wire logic        enc_frame,
    input  wire logic        enc_sdo,
    output logic [7:0]       sent_first_byte,
    output logic             enc_reply_valid,
    output logic [12:0]      enc_position,
    output logic [11:0]      enc_turns,
    output logic             enc_alarm,
    output logic [15:0]      enc_param
);
    logic frame_d;
    initial frame_d = 1'b0;
    initial enc_reply_valid = 1'b0;
    // Stale fields are inverted so a late sample cannot pass
    assign enc_position = enc_reply_valid ? POS : ~POS;
    assign enc_turns    = enc_reply_valid ? TURNS : ~TURNS;
    assign enc_alarm    = enc_reply_valid ? ALARM : ~ALARM;
    assign enc_param    = enc_reply_valid ? PARAM : ~PARAM;
    // Frame cycle count; bits of the first byte stand in counts 2 to 9
    int fcnt = 0;
    always @(posedge aclk) begin
        if (!enc_frame) begin
            fcnt <= 0;
        end else begin
            fcnt <= fcnt + 1;
            if (fcnt >= 2 && fcnt <= 9) sent_first_byte <= {sent_first_byte[6:0], enc_sdo};
        end
    end
    always @(posedge aclk) begin
        frame_d <= enc_frame;
        if (frame_d && !enc_frame) begin
            repeat (3) @(posedge aclk);
            enc_reply_valid <= 1'b1;
            @(posedge aclk);
            enc_reply_valid <= 1'b0;
        end
    end
endmodule

//--- ecb_link.sv
// Purpose: Encoder side bit shifter, one byte per request
// Assumes: Byte framing stands for the serial line
// Notes:   MSB first, one bit per clock
`timescale 1ns/10ps
module ecb_link (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       go,
    input  wire logic [7:0] din,
    output logic            busy,
    output logic            done,
    output logic            sdo
);
    import ecb_pkg::*;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       done_next;
    always_comb begin
        sh_next   = sh_reg;
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        if (cnt_reg != 4'h0) begin
            sh_next  = {sh_reg[6:0], 1'b0};
            cnt_next = cnt_reg - 4'h1;
            done_next = (cnt_reg == 4'h1);
        end else if (go) begin
            sh_next  = din;
            cnt_next = 4'h8;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_reg  <= 8'h00;
            cnt_reg <= 4'h0;
            done    <= 1'b0;
        end else begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_next;
            done    <= done_next;
        end
    end
    assign busy = (cnt_reg != 4'h0);
    assign sdo  = sh_reg[7];
endmodule

//--- ecb_msg_mem.sv
// Purpose: Byte store for one message
// Assumes: One write and one registered read port
// Notes:   Read data come from a register
`timescale 1ns/10ps
module ecb_msg_mem (
    input  wire logic                     aclk,
    input  wire logic                     we,
    input  wire logic [ecb_pkg::PTR_W-1:0] waddr,
    input  wire logic [7:0]               wdata,
    input  wire logic [ecb_pkg::PTR_W-1:0] raddr,
    output logic      [7:0]               rdata
);
    import ecb_pkg::*;
    logic [7:0] mem [MSG_DEPTH];
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        // Bypass so a byte written and read on one edge is not stale
        rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
    end
endmodule

//--- ecb_pkg.sv
// Purpose: Constants for the encoder comms buffer
// Assumes: One clock, AXI4-Lite register access
// Notes:   Register offsets are byte addresses
//
// Summary of operation
// - Device clears the transmit word to zero once it has taken the latest word.
// - A transmit word with bit 14 set starts sending the collected bytes to the encoder; the code starts only when bit 15 is set as well.
// - Each reply byte goes to the receive word low byte with bit 15 set, first byte first.
// - Host reads then clears the receive word; only then is the next reply byte loaded.
// - Position reply byte five holds position bit 0 in bit 7 and alarm in bit 6.
// - Position reply byte seven holds position 12-9 low and turns 3-0 high.
// - Byte six holds position 8-1, byte eight turns 11-4 and carries bit 14.
// - A send-parameter reply is address then two data bytes, upper first, last with bit 14; the code sends 00 in place of the address.
package ecb_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_TX     = 4'h0;
    localparam logic [3:0] ADDR_RX     = 4'h4;
    localparam logic [3:0] ADDR_CTRL   = 4'h8;
    localparam logic [3:0] ADDR_STAT   = 4'hc;
    localparam logic [3:0] ADDR_IMASK  = 4'h0;  // Second page, see bank bit
    localparam logic       PAGE_LOW    = 1'b0;
    localparam int         ADDR_W      = 5;
    // ****************************************
    // Word fields
    // ****************************************
    localparam int         BIT_VALID   = 15;
    localparam int         BIT_LAST    = 14;
    localparam int         BIT_FIRST   = 13;
    localparam int         MSG_DEPTH   = 16;
    localparam int         PTR_W       = 4;
    localparam logic [15:0] WORD_ZERO  = 16'h0000;
    localparam logic [7:0] CMD_POS     = 8'h00;
    localparam int         POS_BYTES   = 8;
    localparam int         PAR_BYTES   = 3;
    // Interrupt status bits
    localparam int         IRQ_RXRDY   = 0;
    localparam int         IRQ_TXDONE  = 1;
    localparam int         IRQ_W       = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_COLLECT, ST_SEND, ST_WAIT, ST_REPLY} ecb_state_t;
endpackage

//--- ecb_top.sv
// Purpose: Encoder comms buffer with AXI4-Lite registers
// Assumes: Encoder reply arrives as decoded fields on ports
// Notes:   Reply byte builder decodes position and turns
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module ecb_top (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [ecb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [ecb_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       enc_reply_valid,
    input  wire logic [12:0]                enc_position,
    input  wire logic [11:0]                enc_turns,
    input  wire logic                       enc_alarm,
    input  wire logic [15:0]                enc_param,
    output logic                            enc_sdo,
    output logic                            enc_frame,
    output logic                            position_check_disable,
    output logic                            irq
);
    import ecb_pkg::*;
    // ****************************************
    // Bus slave
    // ****************************************
    logic                aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [ADDR_W-1:0]   awa_reg, awa_next;
    logic [31:0]         wd_reg, wd_next;
    logic [3:0]          ws_reg, ws_next;
    logic                bvalid_next, rvalid_next, arready_next;
    logic [1:0]          bresp_next, rresp_next;
    logic [31:0]         rdata_next;
    logic                wr_go, rd_go;
    logic [15:0]         tx_reg, tx_next, rx_reg, rx_next;
    logic                pcd_next;
    logic [IRQ_W-1:0]    ist_reg, ist_next, imask_reg, imask_next;
    logic                irq_next;
    ecb_state_t          st_reg, st_next;
    logic [PTR_W-1:0]    wp_reg, wp_next, rp_reg, rp_next;
    logic [PTR_W-1:0]    rcnt_reg, rcnt_next, rlen_reg, rlen_next;
    logic                is_pos_reg, is_pos_next;
    logic [7:0]          mem_rd, rbyte;
    logic                mem_we, link_go, link_busy, link_done, link_sdo, frame_next;
    logic [12:0]         pos_reg, pos_next;
    logic [11:0]         trn_reg, trn_next;
    logic                alm_reg, alm_next;
    logic [15:0]         par_reg, par_next;
    logic                tx_wr, rx_clr_wr;
    logic [15:0]         wd16;

    assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign wd16  = wd_reg[15:0];
    assign tx_wr = wr_go && awa_reg[4] == PAGE_LOW && awa_reg[3:0] == ADDR_TX && ws_reg[1];
    assign rx_clr_wr = wr_go && awa_reg[4] == PAGE_LOW && awa_reg[3:0] == ADDR_RX && ws_reg[1];

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awa_next     = awa_reg;
        wd_next      = wd_reg;
        ws_next      = ws_reg;
        bvalid_next  = s_axi_bvalid && !s_axi_bready;
        bresp_next   = s_axi_bresp;
        arready_next = !s_axi_rvalid && !s_axi_arready;
        rvalid_next  = s_axi_rvalid && !s_axi_rready;
        rresp_next   = s_axi_rresp;
        rdata_next   = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            awa_next     = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            wd_next     = s_axi_wdata;
            ws_next     = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (awa_reg[1:0] == 2'h0 && (awa_reg[4] == PAGE_LOW || awa_reg[3:0] == ADDR_IMASK))
                           ? RESP_OKAY : RESP_SLVERR;
        end
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            if (s_axi_araddr[4] != PAGE_LOW) begin
                if (s_axi_araddr[3:0] == ADDR_IMASK) rdata_next = {30'h0, imask_reg};
                else rresp_next = RESP_SLVERR;
            end else begin
                unique case (s_axi_araddr[3:0])
                    ADDR_TX:   rdata_next = {16'h0000, tx_reg};
                    ADDR_RX:   rdata_next = {16'h0000, rx_reg};
                    ADDR_CTRL: rdata_next = {31'h0, position_check_disable};
                    ADDR_STAT: rdata_next = {30'h0, ist_reg};
                    default:   rresp_next = RESP_SLVERR;
                endcase
            end
        end
    end

    // ****************************************
    // Transmit collect, send, reply
    // ****************************************
    always_comb begin
        st_next     = st_reg;
        tx_next     = tx_reg;
        wp_next     = wp_reg;
        rp_next     = rp_reg;
        rcnt_next   = rcnt_reg;
        rlen_next   = rlen_reg;
        is_pos_next = is_pos_reg;
        rx_next     = rx_reg;
        mem_we      = 1'b0;
        link_go     = 1'b0;
        frame_next  = enc_frame;
        pos_next    = pos_reg;
        trn_next    = trn_reg;
        alm_next    = alm_reg;
        par_next    = par_reg;
        if (tx_wr) begin
            tx_next = wd16;
        end
        if (rx_clr_wr && wd16 == WORD_ZERO) begin
            rx_next = WORD_ZERO;
        end
        unique case (st_reg)
            ST_COLLECT: begin
                if (tx_reg != WORD_ZERO) begin
                    tx_next = WORD_ZERO;
                    if (tx_reg[BIT_VALID]) begin
                        mem_we = 1'b1;
                        if (tx_reg[BIT_FIRST]) begin
                            wp_next     = PTR_W'(1);
                            is_pos_next = (tx_reg[7:0] == CMD_POS);
                        end else begin
                            wp_next = wp_reg + PTR_W'(1);
                        end
                        if (tx_reg[BIT_LAST]) begin
                            st_next    = ST_SEND;
                            rp_next    = '0;
                            frame_next = 1'b1;
                        end
                    end
                end
            end
            ST_SEND: begin
                if (!link_busy && !link_go && !link_done) begin
                    if (rp_reg == wp_reg) begin
                        st_next    = ST_WAIT;
                        frame_next = 1'b0;
                    end else begin
                        link_go = 1'b1;
                        rp_next = rp_reg + PTR_W'(1);
                    end
                end
            end
            ST_WAIT: begin
                if (enc_reply_valid) begin
                    pos_next  = enc_position;
                    trn_next  = enc_turns;
                    alm_next  = enc_alarm;
                    par_next  = enc_param;
                    rcnt_next = '0;
                    rlen_next = is_pos_reg ? PTR_W'(POS_BYTES) : PTR_W'(PAR_BYTES);
                    st_next   = ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (rx_reg == WORD_ZERO && !rx_clr_wr) begin
                    rx_next = {1'b1, (rcnt_reg == rlen_reg - PTR_W'(1)), 6'h00, rbyte};
                    rcnt_next = rcnt_reg + PTR_W'(1);
                    if (rcnt_reg == rlen_reg - PTR_W'(1)) st_next = ST_COLLECT;
                end
            end
        endcase
    end

    always_comb begin
        rbyte = 8'h00;
        if (is_pos_reg) begin
            unique case (rcnt_reg)
                4'h4:    rbyte = {pos_reg[0], alm_reg, 6'h00};
                4'h5:    rbyte = pos_reg[8:1];
                4'h6:    rbyte = {trn_reg[3:0], pos_reg[12:9]};
                4'h7:    rbyte = trn_reg[11:4];
                default: rbyte = 8'h00;
            endcase
        end else begin
            unique case (rcnt_reg)
                4'h1:    rbyte = par_reg[15:8];
                4'h2:    rbyte = par_reg[7:0];
                default: rbyte = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Control and interrupts
    // ****************************************
    always_comb begin
        pcd_next   = position_check_disable;
        imask_next = imask_reg;
        ist_next   = ist_reg;
        if (wr_go && ws_reg[0] && awa_reg[4] == PAGE_LOW && awa_reg[3:0] == ADDR_CTRL) pcd_next = wd_reg[0];
        if (wr_go && ws_reg[0] && awa_reg[4] != PAGE_LOW && awa_reg[3:0] == ADDR_IMASK)
            imask_next = wd_reg[IRQ_W-1:0];
        // Clear first so a same-cycle event wins
        if (wr_go && ws_reg[0] && awa_reg[4] == PAGE_LOW && awa_reg[3:0] == ADDR_STAT)
            ist_next = ist_reg & ~wd_reg[IRQ_W-1:0];
        if (st_reg == ST_REPLY && rx_next != rx_reg && rx_next[BIT_VALID]) ist_next[IRQ_RXRDY] = 1'b1;
        if (st_reg == ST_SEND && st_next == ST_WAIT) ist_next[IRQ_TXDONE] = 1'b1;
        irq_next = |(ist_next & imask_next);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awa_reg     <= '0;
            wd_reg      <= 32'h0;
            ws_reg      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0;
            st_reg     <= ST_COLLECT;
            tx_reg     <= WORD_ZERO;
            rx_reg     <= WORD_ZERO;
            wp_reg     <= '0;
            rp_reg     <= '0;
            rcnt_reg   <= '0;
            rlen_reg   <= '0;
            is_pos_reg <= 1'b0;
            enc_frame  <= 1'b0;
            pos_reg    <= '0;
            trn_reg    <= '0;
            alm_reg    <= 1'b0;
            par_reg    <= WORD_ZERO;
            position_check_disable <= 1'b0;
            imask_reg  <= '0;
            ist_reg    <= '0;
            irq        <= 1'b0;
            enc_sdo    <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awa_reg     <= awa_next;
            wd_reg      <= wd_next;
            ws_reg      <= ws_next;
            s_axi_awready <= !aw_have_next;
            s_axi_wready  <= !w_have_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_rresp   <= rresp_next;
            s_axi_rdata   <= rdata_next;
            st_reg     <= st_next;
            tx_reg     <= tx_next;
            rx_reg     <= rx_next;
            wp_reg     <= wp_next;
            rp_reg     <= rp_next;
            rcnt_reg   <= rcnt_next;
            rlen_reg   <= rlen_next;
            is_pos_reg <= is_pos_next;
            enc_frame  <= frame_next;
            pos_reg    <= pos_next;
            trn_reg    <= trn_next;
            alm_reg    <= alm_next;
            par_reg    <= par_next;
            position_check_disable <= pcd_next;
            imask_reg  <= imask_next;
            ist_reg    <= ist_next;
            irq        <= irq_next;
            enc_sdo    <= link_sdo;
        end
    end

    ecb_msg_mem u_mem (
        .aclk  (aclk),
        .we    (mem_we),
        .waddr (tx_reg[BIT_FIRST] ? PTR_W'(0) : wp_reg),
        .wdata (tx_reg[7:0]),
        .raddr (rp_next),
        .rdata (mem_rd)
    );

    ecb_link u_link (
        .aclk    (aclk),
        .aresetn (aresetn),
        .go      (link_go),
        .din     (mem_rd),
        .busy    (link_busy),
        .done    (link_done),
        .sdo     (link_sdo)
    );

    // ****************************************
    // Checks
    // ****************************************
    a_tx_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_COLLECT && tx_reg != WORD_ZERO) |=> tx_reg == WORD_ZERO || $past(tx_wr))
        else $error("transmit word not cleared");
    a_last_starts: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_COLLECT && tx_reg[BIT_VALID] && tx_reg[BIT_LAST]) |=> st_reg == ST_SEND)
        else $error("last byte did not start send");
    a_invalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_COLLECT && tx_reg != WORD_ZERO && !tx_reg[BIT_VALID]) |=> st_reg == ST_COLLECT)
        else $error("invalid word acted on");
    a_rx_valid: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(st_reg) == ST_REPLY && $changed(rcnt_reg)) |-> rx_reg[BIT_VALID])
        else $error("reply byte without valid");
    a_rx_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (rx_reg != WORD_ZERO && !rx_clr_wr) |=> rx_reg == $past(rx_reg))
        else $error("reply overwritten before clear");
    a_alarm_byte: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_REPLY && is_pos_reg && rcnt_reg == 4'h4 && rx_reg == WORD_ZERO && !rx_clr_wr)
        |=> rx_reg[7:6] == {pos_reg[0], alm_reg})
        else $error("alarm byte wrong");
    a_turn_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_REPLY && is_pos_reg && rcnt_reg == 4'h6 && rx_reg == WORD_ZERO && !rx_clr_wr)
        |=> rx_reg[7:0] == {trn_reg[3:0], pos_reg[12:9]})
        else $error("seventh byte wrong");
    a_last_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_REPLY && rcnt_reg == rlen_reg - PTR_W'(1) && rx_reg == WORD_ZERO && !rx_clr_wr)
        |=> rx_reg[BIT_LAST] && st_reg == ST_COLLECT)
        else $error("last reply byte flag missing");
    a_param_hi: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == ST_REPLY && !is_pos_reg && rcnt_reg == 4'h1 && rx_reg == WORD_ZERO && !rx_clr_wr)
        |=> rx_reg[7:0] == par_reg[15:8])
        else $error("parameter upper byte wrong");
endmodule

//--- encoder_comms_buffer_tb_top.sv
// Purpose: Self-checking bench for the encoder comms buffer
// Assumes: AXI4-Lite master tasks, encoder model on the far side
// Notes:   Host rules are kept by the stimulus sequence
`timescale 1ns/10ps
module encoder_comms_buffer_tb_top;
    import ecb_pkg::*;
    localparam logic [12:0] P = 13'h1d3e;
    localparam logic [11:0] T = 12'h744;
    logic aclk = 0, aresetn = 0;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic [1:0] rs;
    logic enc_reply_valid, enc_alarm, enc_sdo, enc_frame, position_check_disable, irq;
    logic [12:0] enc_position;
    logic [11:0] enc_turns;
    logic [15:0] enc_param;
    logic [7:0] sent_first_byte;
    logic [15:0] txq[$], rxq[$];
    int n_errors = 0, compares = 0;
    initial forever #2 aclk = ~aclk;
    ecb_top ecb_top_i (.*);
    ecb_enc_model #(.POS(P), .TURNS(T), .ALARM(1'b1), .PARAM(16'h1234)) ecb_enc_model_i (.*);
    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        // Ready stays high so a following call never re-raises it in one step
        rs = s_axi_bresp;
    endtask
    task automatic axr(input logic [4:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata; rs = s_axi_rresp;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            n_errors++;
        end
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Sends txq, then drains the reply and compares it against rxq
    task automatic run_msg;
        int k;
        foreach (txq[i]) begin
            k = 0;
            do begin axr(5'h00); k++; end while (rd[15:0] !== 16'h0 && k < 50);
            chk("tx_taken", 32'h0, rd);
            axw(5'h00, {16'h0, txq[i]});
        end
        k = 0;
        while (enc_frame !== 1'b1 && k < 100) begin @(posedge aclk); k++; end
        chk("frame", 1, enc_frame);
        foreach (rxq[i]) begin
            k = 0;
            do begin axr(5'h04); k++; end while (rd[15] !== 1'b1 && k < 400);
            chk("rx_byte", rxq[i], rd);
            chk("irq", 1, irq);
            axr(5'h04);
            chk("rx_hold", rxq[i], rd);
            axw(5'h04, 32'h0);
        end
        chk("sent_byte", {24'h0, txq[0][7:0]}, {24'h0, sent_first_byte});
        axr(5'h00);
        chk("tx_idle", 32'h0, rd);
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axr(5'h04); chk("rx_reset", 32'h0, rd);
        chk("irq_reset", 0, irq);
        axw(5'h08, 32'h1); chk("pcd", 1, position_check_disable);
        axw(5'h10, 32'h3);
        txq = '{16'ha000, 16'hc000};
        rxq = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, {8'h80, P[0], 1'b1, 6'h0},
                {8'h80, P[8:1]}, {8'h80, T[3:0], P[12:9]}, {8'hc0, T[11:4]}};
        run_msg();
        txq = '{16'ha004, 16'h8000, 16'h8000, 16'hc000};
        rxq = '{16'h8000, 16'h8012, 16'hc034};
        run_msg();
        axw(5'h00, 32'h0055);
        axr(5'h00); chk("tx_invalid", 32'h0, rd);
        txq = '{16'he000};
        rxq = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, {8'h80, P[0], 1'b1, 6'h0},
                {8'h80, P[8:1]}, {8'h80, T[3:0], P[12:9]}, {8'hc0, T[11:4]}};
        run_msg();
        axw(5'h0c, 32'h3);
        axr(5'h0c); chk("status_clr", 32'h0, rd);
        chk("irq_clr", 0, irq);
        axr(5'h14); chk("unmapped", RESP_SLVERR, rs);
        axw(5'h08, 32'h0); chk("pcd_off", 0, position_check_disable);
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end
endmodule
